// ===== pbxs_clk_switch.sv
`timescale 1ns/1ps
`default_nettype none
module pbxs_clk_switch #(
    parameter int W = 6
) (
    input  wire logic         clk_in,
    input  wire logic         rstn_in,
    input  wire logic         req_pll_in,
    input  wire logic [W-1:0] req_div_in,
    input  wire logic         load_ok_in,
    output logic              use_pll_out,
    output logic [W-1:0]      div_out
);
    logic         next_use_pll;
    logic [W-1:0] next_div;

    // A new selection is taken only between output periods, so no period is cut short.
    always_comb begin
        next_use_pll = use_pll_out;
        next_div     = div_out;
        if (load_ok_in) begin
            next_use_pll = req_pll_in;
            next_div     = req_div_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            use_pll_out <= 1'b0;
            div_out     <= '0;
        end else begin
            use_pll_out <= next_use_pll;
            div_out     <= next_div;
        end
    end
endmodule : pbxs_clk_switch
`default_nettype wire

// ===== pbxs_clock_ctrl.sv
// Functional notes
// - Extended override uses extended divisor field.
// - Bit 13 drives PLL power down, reset one.
// - Bypass set clocks system from oscillator.
// - Bypass clear uses divided PLL output.
// - Crystal field bits 9:6, reset 0xB.
// - Crystal codes decode to listed frequencies.
// - Reserved bits read fixed zero or one.
// - PLL in use clamps divisor to minimum.
// - Divider forced on when PLL selected.
// - Oscillator source field bits 5:4, reset one.
// - Extended fields replace base fields when set.
`timescale 1ns/1ps
`default_nettype none
module pbxs_clock_ctrl #(
    parameter logic [5:0] MIN_SYSCLK_DIVISOR = pbxs_pkg::MIN_SYSCLK_DIVISOR_DEF
) (
    input  wire logic                        clk_in,
    input  wire logic                        rstn_in,
    input  wire logic [pbxs_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [31:0]                 wdata_in,
    input  wire logic                        wr_in,
    input  wire logic                        rd_in,
    output logic      [31:0]                 rdata_out,
    input  wire logic                        osc_tick_in,
    input  wire logic                        pll_tick_in,
    output logic                             sys_tick_out,
    output logic                             sysclk_from_pll_out,
    output logic                             pll_power_down_out,
    output logic                             pll_bypass_out,
    output logic      [pbxs_pkg::OSC_W-1:0]  osc_source_out,
    output logic      [pbxs_pkg::DIV_W-1:0]  sysclk_divisor_out,
    output logic      [3:0]                  crystal_freq_select_out,
    output logic      [31:0]                 crystal_freq_hz_out,
    output logic                             crystal_pll_ok_out
);
    logic [31:0]                run_clock_configuration;
    logic [31:0]                run_clock_configuration_ext;
    logic [31:0]                next_cfg;
    logic [31:0]                next_ext;
    logic [31:0]                next_rdata;

    logic                       use_extended_config;
    logic                       sel_pll_power_down;
    logic                       sel_bypass;
    logic [pbxs_pkg::OSC_W-1:0] sel_osc;
    logic [pbxs_pkg::DIV_W-1:0] raw_div;
    logic [pbxs_pkg::DIV_W-1:0] eff_div;
    logic                       divider_on;
    logic [3:0]                 crystal_freq_select;

    logic                       next_pll_power_down_out;
    logic                       next_bypass_out;
    logic [pbxs_pkg::OSC_W-1:0] next_osc_out;
    logic [pbxs_pkg::DIV_W-1:0] next_div_out;
    logic [31:0]                next_hz_out;
    logic                       next_pll_ok_out;

    logic                       applied_pll;
    logic [pbxs_pkg::DIV_W-1:0] applied_div;
    logic                       div_idle;
    logic                       src_tick;

    // Register writes store only the writable bits, so reserved bits cannot be set.
    always_comb begin
        next_cfg = run_clock_configuration;
        next_ext = run_clock_configuration_ext;
        if (wr_in && addr_in == pbxs_pkg::RUN_CFG_OFS) begin
            next_cfg = wdata_in & pbxs_pkg::RUN_CFG_MASK;
        end
        if (wr_in && addr_in == pbxs_pkg::RUN_CFG_EXT_OFS) begin
            next_ext = wdata_in & pbxs_pkg::EXT_MASK;
        end
    end

    // Read data stand for one cycle only; unmapped addresses read zero.
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (rd_in && addr_in == pbxs_pkg::RUN_CFG_OFS) begin
            next_rdata = run_clock_configuration | pbxs_pkg::RUN_CFG_ONES;
        end else if (rd_in && addr_in == pbxs_pkg::RUN_CFG_EXT_OFS) begin
            next_rdata = run_clock_configuration_ext;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            run_clock_configuration     <= pbxs_pkg::RUN_CFG_RST & pbxs_pkg::RUN_CFG_MASK;
            run_clock_configuration_ext <= pbxs_pkg::EXT_RST & pbxs_pkg::EXT_MASK;
            rdata_out                   <= 32'h0000_0000;
        end else begin
            run_clock_configuration     <= next_cfg;
            run_clock_configuration_ext <= next_ext;
            rdata_out                   <= next_rdata;
        end
    end

    assign use_extended_config = run_clock_configuration_ext[pbxs_pkg::USE_EXT_BIT];
    assign crystal_freq_select =
        run_clock_configuration[pbxs_pkg::CRYSTAL_FREQ_SELECT_LSB +: pbxs_pkg::CRYSTAL_FREQ_SELECT_W];

    // Field selection between the base and the extended register.
    always_comb begin
        if (use_extended_config) begin
            sel_pll_power_down  = run_clock_configuration_ext[pbxs_pkg::PLL_POWER_DOWN_BIT];
            sel_bypass = run_clock_configuration_ext[pbxs_pkg::BYPASS_BIT];
            sel_osc    = run_clock_configuration_ext[pbxs_pkg::OSC_LSB +: pbxs_pkg::OSC_W];
            raw_div    = run_clock_configuration_ext[pbxs_pkg::SYSCLK_DIVISOR_LSB +:
                                                     pbxs_pkg::EXT_SYSCLK_DIVISOR_W];
        end else begin
            sel_pll_power_down  = run_clock_configuration[pbxs_pkg::PLL_POWER_DOWN_BIT];
            sel_bypass = run_clock_configuration[pbxs_pkg::BYPASS_BIT];
            sel_osc    = {1'b0,
                          run_clock_configuration[pbxs_pkg::OSC_LSB +: pbxs_pkg::OSC_BASE_W]};
            raw_div    = {2'b00,
                          run_clock_configuration[pbxs_pkg::SYSCLK_DIVISOR_LSB +: pbxs_pkg::SYSCLK_DIVISOR_W]};
        end
        divider_on = !sel_bypass || run_clock_configuration[pbxs_pkg::DIV_EN_BIT];
        if (!divider_on) begin
            eff_div = '0;
        end else if (!sel_bypass && raw_div < MIN_SYSCLK_DIVISOR) begin
            eff_div = MIN_SYSCLK_DIVISOR;
        end else begin
            eff_div = raw_div;
        end
    end

    always_comb begin
        next_pll_power_down_out  = sel_pll_power_down;
        next_bypass_out = sel_bypass;
        next_osc_out    = sel_osc;
        next_div_out    = eff_div;
        next_hz_out     = pbxs_pkg::crystal_hz(crystal_freq_select);
        // Low codes carry no PLL setting; software must avoid them with the PLL.
        next_pll_ok_out = crystal_freq_select >= pbxs_pkg::CRYSTAL_FREQ_SELECT_PLL_MIN;
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pll_power_down_out      <= 1'b1;
            pll_bypass_out          <= 1'b1;
            osc_source_out          <= 3'h1;
            sysclk_divisor_out      <= 6'h00;
            crystal_freq_select_out <= 4'hB;
            crystal_freq_hz_out     <= 32'h0000_0000;
            crystal_pll_ok_out      <= 1'b1;
        end else begin
            pll_power_down_out      <= next_pll_power_down_out;
            pll_bypass_out          <= next_bypass_out;
            osc_source_out          <= next_osc_out;
            sysclk_divisor_out      <= next_div_out;
            crystal_freq_select_out <= crystal_freq_select;
            crystal_freq_hz_out     <= next_hz_out;
            crystal_pll_ok_out      <= next_pll_ok_out;
        end
    end

    pbxs_clk_switch #(
        .W (pbxs_pkg::DIV_W)
    ) u_switch (
        .clk_in      (clk_in),
        .rstn_in     (rstn_in),
        .req_pll_in  (!sel_bypass),
        .req_div_in  (eff_div),
        .load_ok_in  (div_idle),
        .use_pll_out (applied_pll),
        .div_out     (applied_div)
    );

    // Source ticks come from logic on this clock, so they need no synchroniser.
    assign src_tick = applied_pll ? pll_tick_in : osc_tick_in;

    pbxs_sysclk_div #(
        .W (pbxs_pkg::DIV_W)
    ) u_div (
        .clk_in      (clk_in),
        .rstn_in     (rstn_in),
        .src_tick_in (src_tick),
        .div_in      (applied_div),
        .tick_out    (sys_tick_out),
        .idle_out    (div_idle)
    );

    assign sysclk_from_pll_out = applied_pll;

    a_ext_divisor: assert property (@(posedge clk_in) disable iff (!rstn_in)
        use_extended_config && !run_clock_configuration_ext[pbxs_pkg::BYPASS_BIT] &&
        run_clock_configuration_ext[28:23] >= MIN_SYSCLK_DIVISOR
        |=> sysclk_divisor_out == $past(run_clock_configuration_ext[28:23]))
        else $error("extended divisor not applied");

    a_pll_power_down_follow: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !use_extended_config |=> pll_power_down_out == $past(run_clock_configuration[13]))
        else $error("power down output does not follow bit 13");

    a_bypass_osc: assert property (@(posedge clk_in) disable iff (!rstn_in)
        sel_bypass && div_idle |=> !applied_pll)
        else $error("bypass did not select the oscillator");

    a_pll_source: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !sel_bypass && div_idle |=> applied_pll && applied_div == $past(eff_div))
        else $error("PLL path not selected with its divisor");

    a_crystal_decode: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rstn_in |=> crystal_freq_hz_out == pbxs_pkg::crystal_hz($past(crystal_freq_select)))
        else $error("crystal frequency decode wrong");

    a_reserved_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rd_in && addr_in == pbxs_pkg::RUN_CFG_OFS
        |=> rdata_out[21:14] == 8'h00 && rdata_out[12] && !rdata_out[10])
        else $error("reserved bits read wrong");

    a_min_clamp: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !sel_bypass && raw_div < MIN_SYSCLK_DIVISOR |=> sysclk_divisor_out == MIN_SYSCLK_DIVISOR)
        else $error("divisor not clamped with PLL in use");

    a_div_forced: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !sel_bypass && !run_clock_configuration[pbxs_pkg::DIV_EN_BIT]
        |=> sysclk_divisor_out >= MIN_SYSCLK_DIVISOR)
        else $error("divider not used with PLL selected");

    a_osc_field: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !use_extended_config |=> osc_source_out == {1'b0, $past(run_clock_configuration[5:4])})
        else $error("oscillator source output wrong");

    a_glitch_free: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $changed(applied_div) || $changed(applied_pll) |-> $past(div_idle))
        else $error("selection changed inside a divided period");

    a_crystal_freq_select_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_in && addr_in == pbxs_pkg::RUN_CFG_OFS
        |=> ##1 crystal_freq_select_out == $past(wdata_in[9:6], 2))
        else $error("crystal field write not stored");

    // Register checks: reserved bits drop on write and read data stand for one cycle.
    a_base_store: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_in && addr_in == pbxs_pkg::RUN_CFG_OFS
        |=> run_clock_configuration == ($past(wdata_in) & pbxs_pkg::RUN_CFG_MASK))
        else $error("base register write stored reserved bits");

    a_ext_store: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_in && addr_in == pbxs_pkg::RUN_CFG_EXT_OFS
        |=> run_clock_configuration_ext == ($past(wdata_in) & pbxs_pkg::EXT_MASK))
        else $error("extended register write stored wrong");

    a_ext_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rd_in && addr_in == pbxs_pkg::RUN_CFG_EXT_OFS
        |=> rdata_out == $past(run_clock_configuration_ext))
        else $error("extended register read wrong");

    a_rdata_idle: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !rd_in
        |=> rdata_out == 32'h0000_0000)
        else $error("read data not cleared after one cycle");

    // Output checks wait one edge after reset, because the frequency output resets to zero.
    a_bypass_out: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rstn_in
        |=> pll_bypass_out == $past(sel_bypass))
        else $error("bypass output does not follow selection");

    a_ext_pll_power_down: assert property (@(posedge clk_in) disable iff (!rstn_in)
        use_extended_config
        |=> pll_power_down_out == $past(run_clock_configuration_ext[13]))
        else $error("extended power down not applied");

    a_ext_osc: assert property (@(posedge clk_in) disable iff (!rstn_in)
        use_extended_config
        |=> osc_source_out == $past(run_clock_configuration_ext[6:4]))
        else $error("extended oscillator source not applied");

    a_crystal_freq_select_out: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rstn_in
        |=> crystal_freq_select_out == $past(run_clock_configuration[9:6]))
        else $error("crystal code output wrong");

    a_pll_ok: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rstn_in
        |=> crystal_pll_ok_out == ($past(run_clock_configuration[9:6]) >= 4'h4))
        else $error("crystal PLL flag wrong");

    a_undivided: assert property (@(posedge clk_in) disable iff (!rstn_in)
        sel_bypass && !run_clock_configuration[pbxs_pkg::DIV_EN_BIT]
        |=> sysclk_divisor_out == 6'h00)
        else $error("divider active in bypass without enable");

    a_low_div: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !use_extended_config && sel_bypass && run_clock_configuration[pbxs_pkg::DIV_EN_BIT]
        |=> sysclk_divisor_out == {2'b00, $past(run_clock_configuration[26:23])})
        else $error("divisor clamped without PLL in use");

    a_tick_source: assert property (@(posedge clk_in) disable iff (!rstn_in)
        sys_tick_out
        |-> $past(src_tick))
        else $error("system tick without a source tick");

    a_div_applied: assert property (@(posedge clk_in) disable iff (!rstn_in)
        div_idle
        |=> applied_div == $past(eff_div))
        else $error("divisor not loaded at period boundary");
endmodule : pbxs_clock_ctrl
`default_nettype wire

// ===== pbxs_pkg.sv
`default_nettype none
package pbxs_pkg;

    localparam int          ADDR_W          = 12;
    localparam int          DIV_W           = 6;
    localparam int          OSC_W           = 3;

    localparam logic [11:0] RUN_CFG_OFS     = 12'h060;
    localparam logic [11:0] RUN_CFG_EXT_OFS = 12'h070;

    localparam logic [31:0] RUN_CFG_RST     = 32'h0780_3AD1;
    localparam logic [31:0] RUN_CFG_MASK    = 32'h0FC0_2BF3;
    localparam logic [31:0] RUN_CFG_ONES    = 32'h0000_1000;
    localparam logic [31:0] EXT_RST         = 32'h0780_2810;
    localparam logic [31:0] EXT_MASK        = 32'h9F80_2870;

    localparam int          USE_EXT_BIT     = 31;
    localparam int          SYSCLK_DIVISOR_LSB      = 23;
    localparam int          SYSCLK_DIVISOR_W        = 4;
    localparam int          EXT_SYSCLK_DIVISOR_W    = 6;
    localparam int          DIV_EN_BIT      = 22;
    localparam int          RSV_HI_LSB      = 14;
    localparam int          RSV_HI_W        = 8;
    localparam int          PLL_POWER_DOWN_BIT       = 13;
    localparam int          RSV_ONE_BIT     = 12;
    localparam int          BYPASS_BIT      = 11;
    localparam int          RSV_ZERO_BIT    = 10;
    localparam int          CRYSTAL_FREQ_SELECT_LSB        = 6;
    localparam int          CRYSTAL_FREQ_SELECT_W          = 4;
    localparam int          OSC_LSB         = 4;
    localparam int          OSC_BASE_W      = 2;

    localparam logic [5:0]  MIN_SYSCLK_DIVISOR_DEF  = 6'h03;
    localparam logic [3:0]  CRYSTAL_FREQ_SELECT_PLL_MIN    = 4'h4;

    // Crystal frequency in hertz for each crystal code.
    function automatic logic [31:0] crystal_hz(input logic [3:0] code);
        logic [31:0] hz;
        hz = 32'h0000_0000;
        unique case (code)
            4'h0: hz = 32'h000F_4240;
            4'h1: hz = 32'h001C_2000;
            4'h2: hz = 32'h001E_8480;
            4'h3: hz = 32'h0025_8000;
            4'h4: hz = 32'h0036_9E99;
            4'h5: hz = 32'h0038_4000;
            4'h6: hz = 32'h003D_0900;
            4'h7: hz = 32'h003E_8000;
            4'h8: hz = 32'h004B_0000;
            4'h9: hz = 32'h004C_4B40;
            4'hA: hz = 32'h004E_2000;
            4'hB: hz = 32'h005B_8D80;
            4'hC: hz = 32'h005D_C000;
            4'hD: hz = 32'h0070_8000;
            4'hE: hz = 32'h007A_1200;
            4'hF: hz = 32'h007D_0000;
        endcase
        return hz;
    endfunction : crystal_hz

endpackage : pbxs_pkg
`default_nettype wire

// ===== pbxs_sysclk_div.sv
`timescale 1ns/1ps
`default_nettype none
module pbxs_sysclk_div #(
    parameter int W = 6
) (
    input  wire logic         clk_in,
    input  wire logic         rstn_in,
    input  wire logic         src_tick_in,
    input  wire logic [W-1:0] div_in,
    output logic              tick_out,
    output logic              idle_out
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         next_tick;

    // Divides the source tick stream by div_in plus one.
    always_comb begin
        next_cnt  = cnt;
        next_tick = 1'b0;
        if (src_tick_in) begin
            if (cnt >= div_in) begin
                next_cnt  = '0;
                next_tick = 1'b1;
            end else begin
                next_cnt = cnt + W'(1);
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            cnt      <= '0;
            tick_out <= 1'b0;
        end else begin
            cnt      <= next_cnt;
            tick_out <= next_tick;
        end
    end

    assign idle_out = (cnt == '0);
endmodule : pbxs_sysclk_div
`default_nettype wire

// ===== tb_pbxs_clock_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pbxs_clock_ctrl;
    logic        clk_in;
    logic        rstn_in;
    logic [11:0] addr_in;
    logic [31:0] wdata_in;
    logic        wr_in;
    logic        rd_in;
    logic [31:0] rdata_out;
    logic        osc_tick_in;
    logic        pll_tick_in;
    logic        sys_tick_out;
    logic        sysclk_from_pll_out;
    logic        pll_power_down_out;
    logic        pll_bypass_out;
    logic [2:0]  osc_source_out;
    logic [5:0]  sysclk_divisor_out;
    logic [3:0]  crystal_freq_select_out;
    logic [31:0] crystal_freq_hz_out;
    logic        crystal_pll_ok_out;
    logic [2:0]  tcnt;
    int          fails;
    int          checks;

    localparam logic [31:0] HZ [16] = '{32'h000F_4240, 32'h001C_2000, 32'h001E_8480,
        32'h0025_8000, 32'h0036_9E99, 32'h0038_4000, 32'h003D_0900, 32'h003E_8000,
        32'h004B_0000, 32'h004C_4B40, 32'h004E_2000, 32'h005B_8D80, 32'h005D_C000,
        32'h0070_8000, 32'h007A_1200, 32'h007D_0000};

    pbxs_clock_ctrl u_dut (
        .clk_in                  (clk_in),
        .rstn_in                 (rstn_in),
        .addr_in                 (addr_in),
        .wdata_in                (wdata_in),
        .wr_in                   (wr_in),
        .rd_in                   (rd_in),
        .rdata_out               (rdata_out),
        .osc_tick_in             (osc_tick_in),
        .pll_tick_in             (pll_tick_in),
        .sys_tick_out            (sys_tick_out),
        .sysclk_from_pll_out     (sysclk_from_pll_out),
        .pll_power_down_out      (pll_power_down_out),
        .pll_bypass_out          (pll_bypass_out),
        .osc_source_out          (osc_source_out),
        .sysclk_divisor_out      (sysclk_divisor_out),
        .crystal_freq_select_out (crystal_freq_select_out),
        .crystal_freq_hz_out     (crystal_freq_hz_out),
        .crystal_pll_ok_out      (crystal_pll_ok_out)
    );

    always #25 clk_in = ~clk_in;

    // Free-running sources with different periods so the selected one can be told apart.
    always @(posedge clk_in) begin
        if (!rstn_in) begin
            tcnt        <= 3'h0;
            pll_tick_in <= 1'b0;
            osc_tick_in <= 1'b0;
        end else begin
            tcnt        <= (tcnt == 3'h5) ? 3'h0 : tcnt + 3'h1;
            pll_tick_in <= (tcnt == 3'h0) || (tcnt == 3'h2) || (tcnt == 3'h4);
            osc_tick_in <= (tcnt == 3'h0) || (tcnt == 3'h3);
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic give_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict

    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1 d = rdata_out;
    endtask : bus_rd

    function automatic logic [31:0] cfg(input logic [5:0] dv, input logic en, input logic pd,
                                        input logic byp, input logic [3:0] x, input logic [2:0] o);
        return (32'(dv) << 23) | (32'(en) << 22) | (32'(pd) << 13) | (32'(byp) << 11)
             | (32'(x) << 6) | (32'(o) << 4);
    endfunction : cfg

    // The selected divisor only loads once the divider count is back at zero, so let it run.
    task automatic settle;
        repeat (100) @(posedge clk_in);
    endtask : settle

    task automatic count_ticks(output int n);
        n = 0;
        repeat (360) begin
            @(posedge clk_in);
            #1 if (sys_tick_out === 1'b1) n++;
        end
    endtask : count_ticks

    task automatic expect_clock(input logic [5:0] dv, input logic pll, input int n_exp);
        int n;
        check("divisor", 32'(sysclk_divisor_out), 32'(dv));
        check("from_pll", 32'(sysclk_from_pll_out), 32'(pll));
        count_ticks(n);
        check("tick_count", 32'(n), 32'(n_exp));
    endtask : expect_clock

    task automatic t_reset_values;
        logic [31:0] d;
        check("pll_power_down_rst", 32'(pll_power_down_out), 32'h1);
        check("bypass_rst", 32'(pll_bypass_out), 32'h1);
        check("osc_rst", 32'(osc_source_out), 32'h1);
        check("crystal_freq_select_rst", 32'(crystal_freq_select_out), 32'hB);
        check("hz_rst", crystal_freq_hz_out, 32'h005B_8D80);
        bus_rd(12'h060, d);
        check("base_rst", d, 32'h0780_3AD1);
        bus_rd(12'h070, d);
        check("ext_rst", d, 32'h0780_2810);
        @(posedge clk_in);
        #1 check("rdata_idle", rdata_out, 32'h0000_0000);
    endtask : t_reset_values

    task automatic t_reserved_bits;
        logic [31:0] d;
        bus_wr(12'h060, 32'hFFFF_FFFF);
        bus_rd(12'h060, d);
        check("base_ones", d, 32'h0FC0_3BF3);
        // Bypass stays set so that crystal code zero is legal.
        bus_wr(12'h060, 32'h0000_0800);
        bus_rd(12'h060, d);
        check("base_zeros", d, 32'h0000_1800);
        bus_rd(12'h064, d);
        check("unmapped", d, 32'h0000_0000);
    endtask : t_reserved_bits

    task automatic t_crystal_codes;
        for (int x = 0; x < 16; x++) begin
            bus_wr(12'h060, cfg(6'h00, 1'b0, 1'b1, 1'b1, 4'(x), 3'h1));
            repeat (3) @(posedge clk_in);
            check("crystal_freq_select", 32'(crystal_freq_select_out), 32'(x));
            check("crystal_freq_select_hz", crystal_freq_hz_out, HZ[x]);
            check("crystal_freq_select_pll_ok", 32'(crystal_pll_ok_out), 32'(x >= 4));
        end
    endtask : t_crystal_codes

    task automatic t_osc_sources;
        for (int o = 0; o < 4; o++) begin
            bus_wr(12'h060, cfg(6'h00, 1'b0, 1'b1, 1'b1, 4'hB, 3'(o)));
            settle();
            check("osc_src", 32'(osc_source_out), 32'(o));
        end
    endtask : t_osc_sources

    task automatic t_pll_path;
        bus_wr(12'h060, cfg(6'h01, 1'b0, 1'b0, 1'b0, 4'hB, 3'h1));
        settle();
        check("pll_power_down_off", 32'(pll_power_down_out), 32'h0);
        expect_clock(6'h03, 1'b1, 45);
        bus_wr(12'h060, cfg(6'h05, 1'b0, 1'b0, 1'b0, 4'hB, 3'h1));
        settle();
        expect_clock(6'h05, 1'b1, 30);
    endtask : t_pll_path

    task automatic t_bypass_path;
        bus_wr(12'h060, cfg(6'h02, 1'b1, 1'b0, 1'b1, 4'hB, 3'h1));
        settle();
        check("bypass_on", 32'(pll_bypass_out), 32'h1);
        expect_clock(6'h02, 1'b0, 40);
        bus_wr(12'h060, cfg(6'h02, 1'b0, 1'b1, 1'b1, 4'hB, 3'h1));
        settle();
        expect_clock(6'h00, 1'b0, 120);
    endtask : t_bypass_path

    task automatic t_extended;
        logic [31:0] d;
        logic [31:0] v;
        v = 32'h8000_0000 | cfg(6'h11, 1'b0, 1'b0, 1'b0, 4'h0, 3'h5);
        bus_wr(12'h070, v);
        bus_rd(12'h070, d);
        check("ext_read", d, v);
        settle();
        check("ext_pll_power_down", 32'(pll_power_down_out), 32'h0);
        check("ext_bypass", 32'(pll_bypass_out), 32'h0);
        check("ext_osc", 32'(osc_source_out), 32'h5);
        expect_clock(6'h11, 1'b1, 10);
        bus_wr(12'h070, 32'h0000_0000);
        settle();
        expect_clock(6'h00, 1'b0, 120);
    endtask : t_extended

    initial begin
        clk_in   = 1'b0;
        rstn_in  = 1'b0;
        addr_in  = 12'h000;
        wdata_in = 32'h0000_0000;
        wr_in    = 1'b0;
        rd_in    = 1'b0;
        fails    = 0;
        checks   = 0;
        repeat (12) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        t_reset_values();
        t_reserved_bits();
        t_crystal_codes();
        t_osc_sources();
        t_pll_path();
        t_bypass_path();
        t_extended();
        give_verdict();
    end

    // The full sequence needs about 3300 cycles; 20000 leaves ample room.
    initial begin
        #(50 * 20000);
        fails++;
        give_verdict();
    end
endmodule : tb_pbxs_clock_ctrl
`default_nettype wire
